/* core/aipr_top.v */
/*
  Audio input port router: pin synchronisers, input type selection,
  SPDIF source mux, master clock gear divider, master timing generator,
  PCM and DSD receive paths and general outputs.
  Assumes a single 10 MHz clock, that every pin input is asynchronous,
  and that pin tristate resolution is done outside from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aipr_defines.vh"

module aipr_top (
  // Clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // Audio pins, inputs
  input wire i_data_clk_pin,
  input wire i_serial_or_right_pin,
  input wire i_frame_or_left_pin,
  input wire i_general_pin_one,
  input wire i_general_pin_two,
  // Audio pins, drive side
  output reg o_data_clk_pin_out,
  output reg o_data_clk_pin_oe,
  output reg o_frame_or_left_pin_out,
  output reg o_frame_or_left_pin_oe,
  // Configuration
  input wire [1:0] i_input_select,
  input wire [1:0] i_auto_select,
  input wire [2:0] i_spdif_select,
  input wire [1:0] i_serial_length,
  input wire [1:0] i_clk_gear,
  input wire i_master_mode,
  input wire i_dop_enable,
  input wire i_osf_bypass,
  input wire i_bias_level,
  input wire i_headphone_shutdown_level,
  // Status and rates
  output reg [2:0] o_mode,
  output reg [6:0] o_filter_div,
  output reg o_raw_is_bit_clock,
  output reg o_mclk_en,
  output reg o_auto_in_master,
  output reg o_spdif_active,
  // Receive data
  output reg o_spdif_stream,
  output reg [31:0] o_left_word,
  output reg [31:0] o_right_word,
  output reg o_word_valid,
  output reg o_dsd_left_bit,
  output reg o_dsd_right_bit,
  output reg o_dsd_valid,
  // General outputs
  output reg o_bias,
  output reg o_headphone_shutdown_out
);

  // ****************************************
  // Modes and functions
  // ****************************************
  localparam MODE_PCM = 3'b001;
  localparam MODE_SPDIF = 3'b010;
  localparam MODE_DSD = 3'b100;

  function [5:0] word_bits;
    input [1:0] len;
    begin
      case (len)
        `AIPR_LEN_16: word_bits = `AIPR_BITS_16;
        `AIPR_LEN_24: word_bits = `AIPR_BITS_24;
        default: word_bits = `AIPR_BITS_32;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Index 0 clock pin, 1 serial pin, 2 frame pin, 3 and 4 general pins.
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  reg [4:0] sync3_reg;
  reg [4:0] pin_reg;
  wire [4:0] pin_raw;
  wire [4:0] pin_next;

  assign pin_raw = {i_general_pin_two, i_general_pin_one, i_frame_or_left_pin,
                    i_serial_or_right_pin, i_data_clk_pin};
  // A change is taken only once stages two and three agree.
  assign pin_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (pin_reg & (sync2_reg ^ sync3_reg));

  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
      pin_reg <= 5'h00;
    end
    else
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg <= pin_next;
    end
  end

  // ****************************************
  // Master clock gear divider
  // ****************************************
  reg [2:0] gear_cnt_reg;
  wire [2:0] gear_limit;

  assign gear_limit = (3'h1 << i_clk_gear) - 3'h1;

  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      gear_cnt_reg <= `AIPR_GEAR_RESET;
      o_mclk_en <= 1'b0;
    end
    else if (gear_cnt_reg >= gear_limit)
    begin
      gear_cnt_reg <= `AIPR_GEAR_RESET;
      o_mclk_en <= 1'b1;
    end
    else
    begin
      gear_cnt_reg <= gear_cnt_reg + 3'h1;
      o_mclk_en <= 1'b0;
    end
  end

  // ****************************************
  // Input type selection
  // ****************************************
  reg [2:0] mode_next;
  reg [7:0] act_cnt_reg;
  reg spdif_src;
  wire auto_sel;

  assign auto_sel = (i_input_select == `AIPR_SEL_AUTO);

  always @*
  begin
    case (i_spdif_select)
      `AIPR_SPDIF_CLK: spdif_src = pin_reg[0];
      `AIPR_SPDIF_SERIAL: spdif_src = pin_reg[1];
      `AIPR_SPDIF_FRAME: spdif_src = pin_reg[2];
      `AIPR_SPDIF_GP1: spdif_src = pin_reg[3];
      `AIPR_SPDIF_GP2: spdif_src = pin_reg[4];
      default: spdif_src = 1'b0;
    endcase
  end

  always @*
  begin
    case (i_input_select)
      `AIPR_SEL_PCM: mode_next = MODE_PCM;
      `AIPR_SEL_SPDIF: mode_next = MODE_SPDIF;
      `AIPR_SEL_DSD: mode_next = MODE_DSD;
      default:
        // Automatic choice is not acted on under master timing.
        mode_next = (!i_master_mode && i_auto_select[`AIPR_AUTO_SPDIF_BIT] && o_spdif_active) ?
                    MODE_SPDIF : MODE_PCM;
    endcase
  end

  // Activity means an edge on the chosen source within the last window.
  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      act_cnt_reg <= 8'h00;
      o_spdif_active <= 1'b0;
      o_spdif_stream <= 1'b0;
      o_mode <= MODE_PCM;
      o_auto_in_master <= 1'b0;
    end
    else
    begin
      o_spdif_stream <= spdif_src;
      if (spdif_src != o_spdif_stream)
        act_cnt_reg <= `AIPR_ACT_WINDOW;
      else if (act_cnt_reg != 8'h00)
        act_cnt_reg <= act_cnt_reg - 8'h01;
      o_spdif_active <= (act_cnt_reg != 8'h00);
      o_mode <= mode_next;
      o_auto_in_master <= auto_sel & i_master_mode;
    end
  end

  // ****************************************
  // Sample rate notation
  // ****************************************
  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      o_filter_div <= `AIPR_FDIV_PCM;
      o_raw_is_bit_clock <= 1'b0;
    end
    else
    begin
      o_raw_is_bit_clock <= (o_mode == MODE_DSD);
      case (o_mode)
        MODE_DSD: o_filter_div <= `AIPR_FDIV_DSD;
        MODE_PCM: o_filter_div <= i_dop_enable ? `AIPR_FDIV_DOP : (i_osf_bypass ? `AIPR_FDIV_BYPASS : `AIPR_FDIV_PCM);
        default: o_filter_div <= `AIPR_FDIV_PCM;
      endcase
    end
  end

  // ****************************************
  // Master timing generator
  // ****************************************
  reg gen_bclk_reg;
  reg gen_frame_reg;
  reg [5:0] gen_bit_reg;
  wire drive_clk;
  wire drive_frame;

  assign drive_clk = i_master_mode & (o_mode != MODE_SPDIF);
  assign drive_frame = i_master_mode & (o_mode == MODE_PCM);

  // Bit clock is half the master clock; frame toggles per word.
  always @(posedge i_core_clk)
  begin
    if (!i_resetn || !drive_clk)
    begin
      gen_bclk_reg <= 1'b0;
      gen_frame_reg <= 1'b0;
      gen_bit_reg <= 6'h00;
    end
    else if (o_mclk_en)
    begin
      gen_bclk_reg <= ~gen_bclk_reg;
      if (gen_bclk_reg)
      begin
        if (gen_bit_reg == word_bits(i_serial_length) - 6'h01)
        begin
          gen_bit_reg <= 6'h00;
          gen_frame_reg <= ~gen_frame_reg;
        end
        else
          gen_bit_reg <= gen_bit_reg + 6'h01;
      end
    end
  end

  // ****************************************
  // Pin direction
  // ****************************************
  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      o_data_clk_pin_out <= 1'b0;
      o_data_clk_pin_oe <= 1'b0;
      o_frame_or_left_pin_out <= 1'b0;
      o_frame_or_left_pin_oe <= 1'b0;
      o_bias <= 1'b0;
      o_headphone_shutdown_out <= 1'b0;
    end
    else
    begin
      o_data_clk_pin_oe <= drive_clk;
      o_data_clk_pin_out <= gen_bclk_reg;
      o_frame_or_left_pin_oe <= drive_frame;
      o_frame_or_left_pin_out <= gen_frame_reg;
      o_bias <= i_bias_level;
      o_headphone_shutdown_out <= i_headphone_shutdown_level;
    end
  end

  // ****************************************
  // PCM and DSD receive
  // ****************************************
  // The generated clocks are used internally, so the receive path sees
  // the same edges that go out on the pins one cycle later.
  reg bclk_old_reg;
  reg frame_old_reg;
  reg [31:0] shift_reg;
  wire bclk_src;
  wire frame_src;
  wire bclk_rise;

  assign bclk_src = drive_clk ? gen_bclk_reg : pin_reg[0];
  assign frame_src = drive_frame ? gen_frame_reg : pin_reg[2];
  assign bclk_rise = bclk_src & ~bclk_old_reg;

  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      bclk_old_reg <= 1'b0;
      frame_old_reg <= 1'b0;
      shift_reg <= 32'h00000000;
      o_left_word <= 32'h00000000;
      o_right_word <= 32'h00000000;
      o_word_valid <= 1'b0;
      o_dsd_left_bit <= 1'b0;
      o_dsd_right_bit <= 1'b0;
      o_dsd_valid <= 1'b0;
    end
    else
    begin
      bclk_old_reg <= bclk_src;
      o_word_valid <= 1'b0;
      o_dsd_valid <= 1'b0;
      if (bclk_rise && o_mode == MODE_PCM)
      begin
        frame_old_reg <= frame_src;
        if (frame_src != frame_old_reg)
        begin
          shift_reg <= {31'h00000000, pin_reg[1]};
          if (!frame_old_reg)
            o_left_word <= shift_reg;
          if (frame_old_reg)
            o_right_word <= shift_reg;
          o_word_valid <= frame_old_reg;
        end
        else
          shift_reg <= {shift_reg[30:0], pin_reg[1]};
      end
      if (bclk_rise && o_mode == MODE_DSD)
      begin
        o_dsd_left_bit <= pin_reg[2];
        o_dsd_right_bit <= pin_reg[1];
        o_dsd_valid <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* core/aipr_defines.vh */
/*
  Constants of the audio input port router: input type codes, field
  positions, divider values and reset values.
  Assumes it is included by its bare name from the design file.
*/
// Summary of operation
// - Raw rate is bit rate in DSD, frame rate otherwise; filter divides 64/4/1/8.
// - Audio master clock is the system clock divided by two to the power of the gear setting.
// - PCM uses frame pin as frame clock, serial pin as data, clock pin.
// - Five-way SPDIF source mux: clock pin, serial, frame, general one, two.
// - SPDIF entered by explicit selection or by auto-select when it permits.
// - DSD takes left on frame pin, right on serial pin, clocked by clock pin.
// - Frame pin drives generated frame clock only in master PCM; else input.
// - Clock pin is input in slave, drives PCM or DSD bit clock in master.
// - Reset low holds everything in reset with all pins undriven.
// - Bias and headphone shutdown outputs are zero in reset, then software set.
// - In master timing, auto input selection is not honoured; choose explicitly.
`ifndef AIPR_DEFINES_VH
`define AIPR_DEFINES_VH

// ****************************************
// Input type selection codes
// ****************************************
`define AIPR_SEL_AUTO 2'h0
`define AIPR_SEL_PCM 2'h1
`define AIPR_SEL_SPDIF 2'h2
`define AIPR_SEL_DSD 2'h3
`define AIPR_AUTO_SPDIF_BIT 1

// ****************************************
// Serial word length codes
// ****************************************
`define AIPR_LEN_16 2'h0
`define AIPR_LEN_24 2'h1
`define AIPR_LEN_32 2'h2
`define AIPR_BITS_16 6'h10
`define AIPR_BITS_24 6'h18
`define AIPR_BITS_32 6'h20

// ****************************************
// SPDIF source codes
// ****************************************
`define AIPR_SPDIF_CLK 3'h1
`define AIPR_SPDIF_SERIAL 3'h2
`define AIPR_SPDIF_FRAME 3'h3
`define AIPR_SPDIF_GP1 3'h4
`define AIPR_SPDIF_GP2 3'h5

// ****************************************
// Filter rate dividers
// ****************************************
`define AIPR_FDIV_DSD 7'h40
`define AIPR_FDIV_DOP 7'h04
`define AIPR_FDIV_PCM 7'h01
`define AIPR_FDIV_BYPASS 7'h08

// ****************************************
// Timing and reset values
// ****************************************
`define AIPR_CLK_HZ 10000000
`define AIPR_ACT_WINDOW 8'hff
`define AIPR_GEAR_RESET 3'h0

`endif

/* test/aipr_chk.sv */
/* Assertions on the ports of the audio input port router.
   Assumes it is bound to aipr_top and that the defines header is on the path. */
`timescale 1ns/1ps
`default_nettype none
`include "aipr_defines.vh"
module aipr_chk (
  // Clock, reset and configuration
  input wire i_core_clk,
  input wire i_resetn,
  input wire [1:0] i_input_select,
  input wire [1:0] i_clk_gear,
  input wire i_master_mode,
  input wire i_dop_enable,
  input wire i_osf_bypass,
  input wire i_bias_level,
  // Watched outputs
  input wire o_data_clk_pin_oe,
  input wire o_frame_or_left_pin_oe,
  input wire [2:0] o_mode,
  input wire [6:0] o_filter_div,
  input wire o_raw_is_bit_clock,
  input wire o_mclk_en,
  input wire o_auto_in_master,
  input wire o_bias
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  // ****
  // Properties
  // ****
  // Gear two held long enough that the pulse seen and the one before it both come from it.
  sequence s_gear_two_steady;
    (i_clk_gear == 2'h2) [*8] ##0 o_mclk_en;
  endsequence
  // Reset checks must stay live while reset is low, so they override the default.
  a_rst_undriven: assert property (disable iff (1'b0) !i_resetn |=>
    !o_data_clk_pin_oe && !o_frame_or_left_pin_oe) else $error("pin driven in reset");
  a_rst_bias_low: assert property (disable iff (1'b0) !i_resetn |=> !o_bias)
    else $error("bias high in reset");
  a_bias_follows: assert property (i_resetn |=> o_bias == $past(i_bias_level))
    else $error("bias does not follow level");
  a_slave_undriven: assert property (!i_master_mode [*6] |->
    !o_data_clk_pin_oe && !o_frame_or_left_pin_oe) else $error("pin driven in slave");
  a_dsd_frame_in: assert property ((o_mode == 3'h4) [*6] |-> !o_frame_or_left_pin_oe)
    else $error("frame pin driven in dsd");
  a_master_drive: assert property ((i_master_mode && i_input_select == `AIPR_SEL_PCM) [*6] |->
    o_data_clk_pin_oe && o_frame_or_left_pin_oe) else $error("master pcm pins not driven");
  a_dsd_rates: assert property ((i_input_select == `AIPR_SEL_DSD) [*3] |-> o_mode == 3'h4 &&
    o_filter_div == `AIPR_FDIV_DSD && o_raw_is_bit_clock) else $error("dsd rate wrong");
  a_pcm_rates: assert property ((i_input_select == `AIPR_SEL_PCM && !i_dop_enable &&
    !i_osf_bypass) [*3] |-> o_mode == 3'h1 && o_filter_div == `AIPR_FDIV_PCM && !o_raw_is_bit_clock)
    else $error("pcm rate wrong");
  a_bypass_div: assert property ((i_input_select == `AIPR_SEL_PCM && !i_dop_enable &&
    i_osf_bypass) [*3] |-> o_filter_div == `AIPR_FDIV_BYPASS) else $error("bypass div wrong");
  a_dop_div: assert property ((i_input_select == `AIPR_SEL_PCM && i_dop_enable) [*3] |->
    o_filter_div == `AIPR_FDIV_DOP) else $error("dop div wrong");
  a_gear_two: assert property (s_gear_two_steady |-> $past(o_mclk_en, 4) && !$past(o_mclk_en, 1) &&
    !$past(o_mclk_en, 2) && !$past(o_mclk_en, 3)) else $error("gear two period wrong");
  a_auto_master: assert property ((i_input_select == `AIPR_SEL_AUTO && i_master_mode) [*3] |->
    o_auto_in_master && o_mode == 3'h1) else $error("auto in master wrong");
endmodule
bind aipr_top aipr_chk chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_input_select(i_input_select),
  .i_clk_gear(i_clk_gear), .i_master_mode(i_master_mode), .i_dop_enable(i_dop_enable),
  .i_osf_bypass(i_osf_bypass), .i_bias_level(i_bias_level), .o_data_clk_pin_oe(o_data_clk_pin_oe),
  .o_frame_or_left_pin_oe(o_frame_or_left_pin_oe), .o_mode(o_mode), .o_filter_div(o_filter_div),
  .o_raw_is_bit_clock(o_raw_is_bit_clock), .o_mclk_en(o_mclk_en), .o_auto_in_master(o_auto_in_master),
  .o_bias(o_bias));
`default_nettype wire

/* test/aipr_src.sv */
/* Behavioural audio source driving the clock, frame and serial pins.
   Assumes tasks are started on a falling core clock edge. */
`timescale 1ns/1ps
`default_nettype none
module aipr_src (
  // Pins driven by the source
  output logic o_clk,
  output logic o_left,
  output logic o_right
);
  // ****
  // Bit transfer
  // ****
  // Five core cycles per half bit keeps the clock above the synchroniser limit.
  localparam int HALF = 500;
  initial
  begin
    o_clk = 1'b0;
    o_left = 1'b0;
    o_right = 1'b0;
  end
  task automatic hold(input logic c, input logic l, input logic r);
    o_clk = c;
    o_left = l;
    o_right = r;
  endtask
  task automatic bit_out(input logic l, input logic r);
    hold(1'b0, l, r);
    #HALF;
    o_clk = 1'b1;
    #HALF;
  endtask
  // Released data lines show the inverse so a stale value is never mistaken for data.
  task automatic idle;
    hold(1'b0, ~o_left, ~o_right);
  endtask
  task automatic send_pcm(input logic [31:0] l, input logic [31:0] r, input int n);
    bit_out(1'b1, ~l[n-1]);
    for (int i = n - 1; i >= 0; i--)
      bit_out(1'b0, l[i]);
    for (int i = n - 1; i >= 0; i--)
      bit_out(1'b1, r[i]);
    bit_out(1'b0, ~r[0]);
    idle;
  endtask
  task automatic send_dsd(input logic [7:0] l, input logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bit_out(l[i], r[i]);
    idle;
  endtask
endmodule
`default_nettype wire

/* test/test_audio_input_port_router.sv */
/* Self-checking bench for the audio input port router.
   Assumes aipr_top, the checker bind and the source model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "aipr_defines.vh"
module test_audio_input_port_router;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] sel = `AIPR_SEL_PCM;
  logic [1:0] asel = 2'h0;
  logic [2:0] ssel = 3'h0;
  logic [1:0] len = `AIPR_LEN_16;
  logic [1:0] gear = 2'h0;
  logic mst = 1'b0, dop = 1'b0, osf = 1'b0, bias = 1'b0, hps = 1'b0, gp1 = 1'b0, gp2 = 1'b0;
  logic s_clk, s_left, s_right, dc_out, dc_oe, fr_out, fr_oe, mclk_en, auto_m, act, strm, wv, hp_o, bias_o;
  logic dl_b, dr_b, dv, rb;
  logic [2:0] mode;
  logic [6:0] fdiv;
  logic [31:0] lw, rw, w, r, m;
  logic [7:0] dl = 8'h00, dr = 8'h00;
  logic [4:0] p;
  logic pc, pf;
  int n_mismatch = 0, num_checks = 0, cnt, fc, nwv = 0;
  // Wire levels are resolved here from the router's output enables.
  wire clk_w = dc_oe ? dc_out : s_clk;
  wire fr_w = fr_oe ? fr_out : s_left;
  always #50 clk = ~clk;
  aipr_src src (.o_clk(s_clk), .o_left(s_left), .o_right(s_right));
  aipr_top uut (.i_core_clk(clk), .i_resetn(rst_n), .i_data_clk_pin(clk_w), .i_serial_or_right_pin(s_right),
    .i_frame_or_left_pin(fr_w), .i_general_pin_one(gp1), .i_general_pin_two(gp2), .o_data_clk_pin_out(dc_out),
    .o_data_clk_pin_oe(dc_oe), .o_frame_or_left_pin_out(fr_out), .o_frame_or_left_pin_oe(fr_oe),
    .i_input_select(sel), .i_auto_select(asel), .i_spdif_select(ssel), .i_serial_length(len), .i_clk_gear(gear),
    .i_master_mode(mst), .i_dop_enable(dop), .i_osf_bypass(osf), .i_bias_level(bias),
    .i_headphone_shutdown_level(hps), .o_mode(mode), .o_filter_div(fdiv), .o_raw_is_bit_clock(rb),
    .o_mclk_en(mclk_en), .o_auto_in_master(auto_m), .o_spdif_active(act), .o_spdif_stream(strm),
    .o_left_word(lw), .o_right_word(rw), .o_word_valid(wv), .o_dsd_left_bit(dl_b), .o_dsd_right_bit(dr_b),
    .o_dsd_valid(dv), .o_bias(bias_o), .o_headphone_shutdown_out(hp_o));
  always @(posedge clk)
    if (dv === 1'b1)
    begin
      dl <= {dl[6:0], dl_b};
      dr <= {dr[6:0], dr_b};
    end
  always @(posedge clk)
    if (wv === 1'b1)
      nwv <= nwv + 1;
  // ****
  // Tasks
  // ****
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task pins(input logic [4:0] v);
    src.hold(v[0], v[2], v[1]);
    gp1 = v[3];
    gp2 = v[4];
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #(20000 * 100);
    n_mismatch++;
    print_verdict;
  end
  // ****
  // Tests
  // ****
  initial
  begin
    cyc(12);
    rst_n = 1'b1;
    bias = 1'b1;
    hps = 1'b1;
    cyc(4);
    chk(bias_o, 1'b1);
    chk(hp_o, 1'b1);
    chk(fdiv, `AIPR_FDIV_PCM);
    chk(rb, 1'b0);
    dop = 1'b1;
    cyc(4);
    chk(fdiv, `AIPR_FDIV_DOP);
    dop = 1'b0;
    osf = 1'b1;
    cyc(4);
    chk(fdiv, `AIPR_FDIV_BYPASS);
    osf = 1'b0;
    for (int g = 0; g < 4; g++)
    begin
      gear = 2'(g);
      cyc(4);
      cnt = 0;
      repeat (64)
      begin
        @(negedge clk);
        if (mclk_en === 1'b1)
          cnt++;
      end
      chk(cnt, 64 >> g);
    end
    for (int k = 0; k < 3; k++)
    begin
      len = 2'(k);
      m = 32'hffffffff >> (16 - 8 * k);
      w = 32'h9abcdef1 & m;
      r = 32'h5a3c96e1 & m;
      src.send_pcm(w, r, 16 + 8 * k);
      cyc(10);
      chk(lw, w);
      chk(rw, r);
    end
    // Each frame sent ends two right words: the lead-in one and the real one.
    chk(nwv, 6);
    sel = `AIPR_SEL_DSD;
    cyc(4);
    chk(fdiv, `AIPR_FDIV_DSD);
    chk(rb, 1'b1);
    src.send_dsd(8'ha6, 8'h3b);
    cyc(10);
    chk(dl, 8'ha6);
    chk(dr, 8'h3b);
    sel = `AIPR_SEL_SPDIF;
    for (int k = 0; k < 6; k++)
    begin
      ssel = 3'(k);
      p = (k == 0) ? 5'h1f : 5'h01 << (k - 1);
      pins(p);
      cyc(10);
      chk(strm, k != 0);
      pins(~p);
      cyc(10);
      chk(strm, 1'b0);
    end
    chk(mode, 3'h2);
    sel = `AIPR_SEL_AUTO;
    asel = 2'h2;
    ssel = `AIPR_SPDIF_GP1;
    repeat (20)
    begin
      gp1 = ~gp1;
      cyc(4);
    end
    chk(act, 1'b1);
    chk(mode, 3'h2);
    asel = 2'h0;
    cyc(6);
    chk(mode, 3'h1);
    sel = `AIPR_SEL_PCM;
    gear = 2'h0;
    len = `AIPR_LEN_16;
    mst = 1'b1;
    cyc(8);
    chk(fr_oe, 1'b1);
    chk(dc_oe, 1'b1);
    cnt = 0;
    fc = 0;
    pc = clk_w;
    pf = fr_w;
    repeat (128)
    begin
      @(negedge clk);
      if (clk_w !== pc)
        cnt++;
      if (fr_w !== pf)
        fc++;
      pc = clk_w;
      pf = fr_w;
    end
    chk(cnt, 128);
    chk(fc, 4);
    sel = `AIPR_SEL_DSD;
    cyc(8);
    chk(fr_oe, 1'b0);
    chk(dc_oe, 1'b1);
    sel = `AIPR_SEL_AUTO;
    cyc(4);
    chk(auto_m, 1'b1);
    chk(mode, 3'h1);
    rst_n = 1'b0;
    cyc(2);
    chk(dc_oe, 1'b0);
    chk(fr_oe, 1'b0);
    chk(bias_o, 1'b0);
    chk(hp_o, 1'b0);
    rst_n = 1'b1;
    mst = 1'b0;
    cyc(4);
    print_verdict;
  end
endmodule
`default_nettype wire
